// ### core/fbw_framer.sv
// Builds the flexible beam weight section extension as a byte stream.
// Assumes an APB master for setup and weights, and a sink with ready.
//
// Overview of operation
// - Extension flows distributed unit to radio unit.
// - Bundle size field sent; shared weights.
// - Little-endian swaps weight byte order.
// - Only section types one and three.
// - Omitted flag picks full or reduced layout.
// - Compression header sets weight width.
// - Block is one bundle's weight vector.
// - Per-bundle parameter precedes its bundle.
// - Bundle count is PRBs over bundle size.
// - Remainder adds one extra bundle.
// - Bundle size zero is refused.
// - Omitted drops header, params and weights.
// - Restart-on-gap bit, default one.
// - Continuity zero on last or disabled.
// - Weights signed, one to sixteen bits.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module fbw_framer
	import fbw_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output fbw_byte_t tx_byte,
	input wire logic tx_ready,
	input wire logic [3:0] trx_count_m1
);
	// Ceiling of PRBs over bundle size
	function automatic logic [8:0] bundles_of(input logic [8:0] prbs, input logic [7:0] bsz);
		logic [8:0] q;
		q = 9'h000;
		// Zero size is refused anyway; keep the count defined
		if (bsz != 8'h00) begin
			q = prbs / {1'b0, bsz};
			if ((prbs % {1'b0, bsz}) != 9'h000) begin
				q = q + 9'h001;
			end
		end
		return q;
	endfunction

	logic [5:0] ctrl_ff;
	fbw_cfg_t cfg_ff;
	logic [8:0] prb_total_ff;
	logic [15:0] wdata_ff;
	logic wdata_full_ff;
	logic [15:0] beam_ff;
	logic err_ff;
	fbw_state_t state_ff;
	fbw_state_t nxt_state;
	logic [15:0] hdr_buf_ff;
	logic [2:0] idx_ff;
	logic [8:0] bund_ff;
	logic [4:0] trx_ff;
	logic byte_sel_ff;
	logic [15:0] len_ff;
	fbw_byte_t tx_ff;
	logic [8:0] bund_total;
	logic [15:0] words_per_bund;
	logic [15:0] body_bytes;
	logic [15:0] total_bytes;
	logic wr_acc;
	logic rd_acc;
	logic start_ok;
	logic advance;
	logic omit;
	logic wgt_bytes2;

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign omit = ctrl_ff[FBW_CTRL_OMIT_BIT];
	assign wgt_bytes2 = (cfg_ff.comp_hdr[4:0] > 5'h08);
	assign bund_total = bundles_of(prb_total_ff, cfg_ff.prb_bundle_size);
	// Weight bytes per bundle: I and Q for each chain
	assign words_per_bund = {11'h000, {1'b0, trx_count_m1} + 5'h01} << (wgt_bytes2 ? 2 : 1);
	// reduced layout carries beam indices only
	assign body_bytes = omit ? {6'h00, bund_total, 1'b0} :
		16'(bund_total) * (16'h0003 + words_per_bund) + 16'h0001;
	assign total_bytes = 16'h0005 + body_bytes;
	assign start_ok = ((cfg_ff.sect_type == FBW_SECT_TYPE_A) || (cfg_ff.sect_type == FBW_SECT_TYPE_B)) &&
		(cfg_ff.prb_bundle_size != 8'h00) && (prb_total_ff != 9'h000) &&
		(cfg_ff.comp_hdr[4:0] != 5'h00) && (cfg_ff.comp_hdr[4:0] <= FBW_WIDTH_MAX);
	assign advance = ~tx_ff.valid | tx_ready;
	assign tx_byte = tx_ff;
	assign pslverr = psel & penable & ~((paddr == FBW_CTRL_OFS) || (paddr == FBW_CFG_OFS) ||
		(paddr == FBW_PRB_OFS) || (paddr == FBW_STAT_OFS) || (paddr == FBW_WDATA_OFS) ||
		(paddr == FBW_BEAM_OFS));

	// Read mux
	always_comb begin
		if (paddr == FBW_CTRL_OFS) begin
			prdata = {26'h0, ctrl_ff};
		end else if (paddr == FBW_CFG_OFS) begin
			prdata = cfg_ff;
		end else if (paddr == FBW_PRB_OFS) begin
			prdata = {23'h0, prb_total_ff};
		end else if (paddr == FBW_STAT_OFS) begin
			prdata = {len_ff, 3'h0, bund_total, wdata_full_ff, err_ff, state_ff != FBW_IDLE, 1'b0};
		end else begin
			prdata = FBW_APB_ZERO;
		end
		if (!rd_acc) begin
			prdata = FBW_APB_ZERO;
		end
	end

	// Control register; start bit self-clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= FBW_CTRL_RST;
		end else if (wr_acc && paddr == FBW_CTRL_OFS) begin
			ctrl_ff <= pwdata[5:0];
		end else begin
			ctrl_ff[FBW_CTRL_START_BIT] <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= FBW_CFG_RST;
			prb_total_ff <= 9'h000;
		end else if (wr_acc && paddr == FBW_CFG_OFS && state_ff == FBW_IDLE) begin
			cfg_ff <= pwdata;
		end else if (wr_acc && paddr == FBW_PRB_OFS && state_ff == FBW_IDLE) begin
			prb_total_ff <= pwdata[8:0];
		end
	end

	// Error flag: set on refused start, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_ff <= 1'b0;
		end else if (ctrl_ff[FBW_CTRL_START_BIT] && state_ff == FBW_IDLE && !start_ok) begin
			err_ff <= 1'b1;
		end else if (wr_acc && paddr == FBW_STAT_OFS && pwdata[2]) begin
			err_ff <= 1'b0;
		end
	end

	// Weight and beam holding words, weight writes ignored while full
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdata_ff <= 16'h0000;
			wdata_full_ff <= 1'b0;
			beam_ff <= 16'h0000;
		end else begin
			if (wr_acc && paddr == FBW_BEAM_OFS) begin
				beam_ff <= pwdata[15:0];
			end
			if (wr_acc && paddr == FBW_WDATA_OFS && !wdata_full_ff) begin
				wdata_ff <= pwdata[15:0];
				wdata_full_ff <= 1'b1;
			end else if (state_ff == FBW_WGT && advance && byte_sel_ff == wgt_bytes2) begin
				wdata_full_ff <= 1'b0;
			end
		end
	end

	// Next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			FBW_IDLE: begin
				if (ctrl_ff[FBW_CTRL_START_BIT] && start_ok) begin
					nxt_state = FBW_HDR;
				end
			end
			FBW_HDR: begin
				if (advance && idx_ff == 3'h4) begin
					nxt_state = omit ? FBW_BEAM : FBW_PARAM;
				end
			end
			FBW_PARAM: begin
				if (advance && (bund_ff != 9'h000 || idx_ff[0])) begin
					nxt_state = FBW_BEAM;
				end
			end
			FBW_BEAM: begin
				if (advance && byte_sel_ff) begin
					if (!omit) begin
						nxt_state = FBW_WGT;
					end else if (bund_ff + 9'h001 == bund_total) begin
						nxt_state = FBW_PAD;
					end
				end
			end
			FBW_WGT: begin
				if (advance && wdata_full_ff && byte_sel_ff == wgt_bytes2 && idx_ff[0] &&
					trx_ff == {1'b0, trx_count_m1}) begin
					nxt_state = (bund_ff + 9'h001 == bund_total) ? FBW_PAD : FBW_PARAM;
				end
			end
			FBW_PAD: begin
				if (advance && (len_ff[1:0] & FBW_ALIGN_MASK) == FBW_ALIGN_MASK) begin
					nxt_state = FBW_DONE;
				end
			end
			FBW_DONE: begin
				if (advance) begin
					nxt_state = FBW_IDLE;
				end
			end
			default: begin
				nxt_state = FBW_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= FBW_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Taken byte count and latched length word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			len_ff <= 16'h0000;
			hdr_buf_ff <= 16'h0000;
		end else if (state_ff == FBW_IDLE) begin
			len_ff <= 16'h0000;
			// Length in 4-byte words, padding included
			hdr_buf_ff <= (total_bytes + 16'h0003) >> 2;
		end else if (advance && tx_ff.valid) begin
			len_ff <= len_ff + 16'h0001;
		end
	end

	// Sequencing counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_ff <= 3'h0;
			bund_ff <= 9'h000;
			trx_ff <= 5'h00;
			byte_sel_ff <= 1'b0;
		end else if (state_ff == FBW_IDLE) begin
			idx_ff <= 3'h0;
			bund_ff <= 9'h000;
			trx_ff <= 5'h00;
			byte_sel_ff <= 1'b0;
		end else if (advance) begin
			case (state_ff)
				FBW_HDR: begin
					idx_ff <= (idx_ff == 3'h4) ? 3'h0 : idx_ff + 3'h1;
				end
				FBW_PARAM: begin
					idx_ff <= {2'h0, (bund_ff == 9'h000) & ~idx_ff[0]};
				end
				FBW_BEAM: begin
					byte_sel_ff <= ~byte_sel_ff;
					if (byte_sel_ff && omit) begin
						bund_ff <= bund_ff + 9'h001;
					end
				end
				FBW_WGT: begin
					if (wdata_full_ff) begin
						if (byte_sel_ff == wgt_bytes2) begin
							byte_sel_ff <= 1'b0;
							idx_ff <= {2'h0, ~idx_ff[0]};
							if (idx_ff[0]) begin
								if (trx_ff == {1'b0, trx_count_m1}) begin
									trx_ff <= 5'h00;
									bund_ff <= bund_ff + 9'h001;
								end else begin
									trx_ff <= trx_ff + 5'h01;
								end
							end
						end else begin
							byte_sel_ff <= 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Output byte register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ff <= '0;
		end else if (advance) begin
			tx_ff <= '0;
			case (state_ff)
				FBW_HDR: begin
					tx_ff.valid <= 1'b1;
					case (idx_ff)
						3'h0: tx_ff.data <= {ctrl_ff[FBW_CTRL_EF_BIT], FBW_EXT_TYPE};
						3'h1: tx_ff.data <= hdr_buf_ff[15:8];
						3'h2: tx_ff.data <= hdr_buf_ff[7:0];
						3'h3: tx_ff.data <= {omit, ctrl_ff[FBW_CTRL_RESTART_BIT], 6'h00};
						default: tx_ff.data <= cfg_ff.prb_bundle_size;
					endcase
				end
				FBW_PARAM: begin
					tx_ff.valid <= 1'b1;
					tx_ff.data <= (bund_ff == 9'h000 && !idx_ff[0]) ? cfg_ff.comp_hdr : cfg_ff.comp_param;
				end
				FBW_BEAM: begin
					tx_ff.valid <= 1'b1;
					tx_ff.data <= byte_sel_ff ? beam_ff[7:0] :
						{ctrl_ff[FBW_CTRL_CONT_EN_BIT] & beam_ff[15] & (bund_ff + 9'h001 != bund_total),
						beam_ff[14:8]};
				end
				FBW_WGT: begin
					tx_ff.valid <= wdata_full_ff;
					if (!wgt_bytes2) begin
						tx_ff.data <= wdata_ff[7:0];
					end else begin
						tx_ff.data <= (byte_sel_ff ^ ctrl_ff[FBW_CTRL_LE_BIT]) ? wdata_ff[7:0] : wdata_ff[15:8];
					end
				end
				FBW_PAD: begin
					// zero padding
					// Taken count lags the byte standing here by one
					tx_ff.valid <= (len_ff[1:0] != 2'h3);
					tx_ff.last <= (len_ff[1:0] == 2'h2);
				end
				default: begin
				end
			endcase
		end
	end
endmodule // fbw_framer

// ### core/fbw_pkg.sv
// Package for the flexible beam weight extension framer.
// Assumes an APB register master and a byte-wide downstream sink on pclk.
package fbw_pkg;
	// Register byte offsets
	localparam logic [7:0] FBW_CTRL_OFS = 8'h00;
	localparam logic [7:0] FBW_CFG_OFS = 8'h04;
	localparam logic [7:0] FBW_PRB_OFS = 8'h08;
	localparam logic [7:0] FBW_STAT_OFS = 8'h0c;
	localparam logic [7:0] FBW_WDATA_OFS = 8'h10;
	localparam logic [7:0] FBW_BEAM_OFS = 8'h14;
	// CTRL fields
	localparam int FBW_CTRL_START_BIT = 0;
	localparam int FBW_CTRL_OMIT_BIT = 1;
	localparam int FBW_CTRL_RESTART_BIT = 2;
	localparam int FBW_CTRL_LE_BIT = 3;
	localparam int FBW_CTRL_CONT_EN_BIT = 4;
	localparam int FBW_CTRL_EF_BIT = 5;
	// Reset values
	localparam logic [5:0] FBW_CTRL_RST = 6'h04;
	localparam logic [31:0] FBW_CFG_RST = 32'h0000_0001;
	// Extension framing constants
	localparam logic [6:0] FBW_EXT_TYPE = 7'h0b;
	localparam logic [7:0] FBW_SECT_TYPE_A = 8'h01;
	localparam logic [7:0] FBW_SECT_TYPE_B = 8'h03;
	localparam logic [4:0] FBW_WIDTH_MAX = 5'h10;
	localparam logic [1:0] FBW_ALIGN_MASK = 2'h3;
	localparam logic [31:0] FBW_APB_ZERO = 32'h0000_0000;

	typedef enum logic [2:0] {
		FBW_IDLE = 3'b000,
		FBW_HDR = 3'b001,
		FBW_PARAM = 3'b011,
		FBW_BEAM = 3'b010,
		FBW_WGT = 3'b110,
		FBW_PAD = 3'b111,
		FBW_DONE = 3'b101
	} fbw_state_t;

	// Byte stream carrier
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} fbw_byte_t;

	// Configuration word: section type, comp header, comp param, bundle size
	typedef struct packed {
		logic [7:0] sect_type;
		logic [7:0] comp_hdr;
		logic [7:0] comp_param;
		logic [7:0] prb_bundle_size;
	} fbw_cfg_t;
endpackage : fbw_pkg

// ### testbench/fbw_framer_sva.sv
// Port checker for the beam weight framer.
// Assumes binding onto fbw_framer, single pclk domain.
`timescale 1ns/10ps
module fbw_framer_sva
	import fbw_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire fbw_byte_t tx_byte,
	input wire logic tx_ready
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	// Access phase of a transfer
	assign acc = psel && penable;
	property p_zero_wait; acc |-> pready; endproperty
	property p_rd_idle; !(acc && !pwrite) |-> prdata == FBW_APB_ZERO; endproperty
	property p_unmapped; acc && paddr > FBW_BEAM_OFS |-> pslverr; endproperty
	property p_mapped; acc && paddr <= FBW_BEAM_OFS && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
	property p_hold;
		tx_byte.valid && !tx_ready |=> tx_byte.valid && $stable(tx_byte.data) && $stable(tx_byte.last);
	endproperty
	property p_last_valid; tx_byte.last |-> tx_byte.valid; endproperty
	property p_pad_zero; tx_byte.last |-> tx_byte.data == 8'h00; endproperty
	property p_quiet_reset; $rose(presetn) |-> !tx_byte.valid; endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("pready low in access");
	a_rd_idle: assert property (p_rd_idle) else $error("prdata not zero outside read");
	a_unmapped: assert property (p_unmapped) else $error("no slave error on unmapped");
	a_mapped: assert property (p_mapped) else $error("slave error on mapped register");
	a_hold: assert property (p_hold) else $error("stalled byte changed");
	a_last_valid: assert property (p_last_valid) else $error("last without valid");
	a_pad_zero: assert property (p_pad_zero) else $error("final pad byte not zero");
	a_quiet_reset: assert property (p_quiet_reset) else $error("stream active after reset");
	c_last: cover property (tx_byte.valid && tx_ready && tx_byte.last);
	c_stall: cover property (tx_byte.valid && !tx_ready);
	c_slverr: cover property (acc && pslverr);
endmodule // fbw_framer_sva

bind fbw_framer fbw_framer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_byte(tx_byte), .tx_ready(tx_ready));

// ### testbench/fbw_sink.sv
// Byte sink standing for the far end of the stream.
// Assumes a valid/ready byte stream on pclk.
`timescale 1ns/10ps
module fbw_sink
	import fbw_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire fbw_byte_t tx_byte,
	input wire logic stall,
	output logic tx_ready
);
	logic [7:0] got[$];
	int last_at = -1;
	logic [1:0] cnt_ff;
	// Ready pattern, slow mode takes one cycle in four
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 2'h0;
			tx_ready <= 1'b0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
			tx_ready <= !stall || cnt_ff == 2'h3;
		end
	end
	always @(posedge pclk) begin
		if (presetn && tx_byte.valid && tx_ready) begin
			// A fresh frame forgets the previous end marker
			if (got.size() == 0) begin
				last_at = -1;
			end
			got.push_back(tx_byte.data);
			if (tx_byte.last) begin
				last_at = got.size() - 1;
			end
		end
	end
endmodule // fbw_sink

// ### testbench/flexible_beam_weight_extension_tb.sv
// Self-checking bench for the beam weight framer.
// Assumes fbw_framer, its checker and the fbw_sink model.
`timescale 1ns/10ps
module flexible_beam_weight_extension_tb
	import fbw_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall = 0, pready, pslverr, tx_ready, slv;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [3:0] trx_count_m1 = 4'h0;
	fbw_byte_t tx_byte;
	int err_total = 0, n_tests = 0;
	logic [31:0] bad_cfg [4] = '{32'h0208_0803, 32'h0108_0800, 32'h0111_1103, 32'h0108_0803};
	logic [31:0] bad_prb [4] = '{32'h0000_0007, 32'h0000_0007, 32'h0000_0007, 32'h0000_0000};
	fbw_framer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_byte(tx_byte), .tx_ready(tx_ready), .trx_count_m1(trx_count_m1));
	fbw_sink u_sink (.pclk(pclk), .presetn(presetn), .tx_byte(tx_byte), .stall(stall), .tx_ready(tx_ready));
	// Clock
	initial begin
		forever #50 pclk = ~pclk;
	end
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One APB transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Wait for the holding word to empty, then write one weight
	task automatic wgt(input logic [15:0] v);
		int n = 0;
		do begin
			apb(1'b0, FBW_STAT_OFS, 32'h0000_0000);
			n++;
		end while (rd[3] !== 1'b0 && n < 200);
		chk("weight taken", rd[3], 32'h0000_0000);
		apb(1'b1, FBW_WDATA_OFS, {16'h0000, v});
	endtask
	// Collect nb bytes and compare
	task automatic frame(input logic [159:0] eb, input int nb);
		int n = 0;
		while (u_sink.got.size() < nb && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		repeat (20) @(posedge pclk);
		chk("byte count", u_sink.got.size(), nb);
		for (int i = 0; i < nb; i++) begin
			chk("stream byte", u_sink.got[i], eb[8 * nb - 1 - 8 * i -: 8]);
		end
		chk("last index", u_sink.last_at, nb - 1);
		u_sink.got.delete();
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (30000) @(posedge pclk);
		err_total++;
		report_and_stop;
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, FBW_CTRL_OFS, 32'h0000_0000);
		chk("ctrl reset", rd, 32'h0000_0004);
		apb(1'b0, FBW_CFG_OFS, 32'h0000_0000);
		chk("cfg reset", rd, 32'h0000_0001);
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk("unmapped error", slv, 32'h0000_0001);
		// Refused starts: section type, zero bundle, wide weight, no PRBs
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, FBW_CFG_OFS, bad_cfg[i]);
			apb(1'b1, FBW_PRB_OFS, bad_prb[i]);
			apb(1'b1, FBW_CTRL_OFS, 32'h0000_0005);
			apb(1'b0, FBW_STAT_OFS, 32'h0000_0000);
			chk("start refused", rd[2], 32'h0000_0001);
			apb(1'b1, FBW_STAT_OFS, 32'h0000_0004);
			apb(1'b0, FBW_STAT_OFS, 32'h0000_0000);
			chk("error cleared", rd[2], 32'h0000_0000);
		end
		// Reduced layout, seven PRBs in bundles of three, slow sink
		stall <= 1'b1;
		apb(1'b1, FBW_CFG_OFS, 32'h0108_0803);
		apb(1'b1, FBW_PRB_OFS, 32'h0000_0007);
		apb(1'b1, FBW_BEAM_OFS, 32'h0000_9234);
		apb(1'b1, FBW_CTRL_OFS, 32'h0000_0007);
		frame(160'h0B00_03C0_0312_3412_3412_3400, 12);
		apb(1'b0, FBW_STAT_OFS, 32'h0000_0000);
		chk("bundle count", rd[12:4], 32'h0000_0003);
		// Full layout, one bundle, one chain, 8-bit weights
		stall <= 1'b0;
		apb(1'b1, FBW_CFG_OFS, 32'h0308_0804);
		apb(1'b1, FBW_PRB_OFS, 32'h0000_0004);
		apb(1'b1, FBW_BEAM_OFS, 32'h0000_1234);
		wgt(16'h005a);
		apb(1'b1, FBW_CTRL_OFS, 32'h0000_0025);
		wgt(16'h00a5);
		frame(160'h8B00_0340_0408_0812_345A_A500, 12);
		// Two chains, 16-bit little-endian weights, continuity enabled
		trx_count_m1 <= 4'h1;
		apb(1'b1, FBW_CFG_OFS, 32'h0110_0702);
		apb(1'b1, FBW_PRB_OFS, 32'h0000_0002);
		apb(1'b1, FBW_BEAM_OFS, 32'h0000_8234);
		wgt(16'h1234);
		apb(1'b1, FBW_CTRL_OFS, 32'h0000_001d);
		wgt(16'habcd);
		wgt(16'h0001);
		wgt(16'hfffe);
		frame(160'h0B00_0540_0210_0702_3434_12CD_AB01_00FE_FF00_0000, 20);
		report_and_stop;
	end
endmodule // flexible_beam_weight_extension_tb
